/* File: verilog/ets_pkg.sv */
// package for the two-wire eeprom slave front end: constants and carrier types
package ets_pkg;
    localparam logic [3:0]  CTRL_CODE       = 4'ha;     // control code 1010
    localparam int          CODE_MSB        = 7;
    localparam int          CODE_LSB        = 4;
    localparam int          CS_MSB          = 3;
    localparam int          CS_LSB          = 1;
    localparam int          RW_BIT          = 0;
    localparam logic        RW_READ         = 1'h1;
    localparam logic [3:0]  BIT_LAST        = 4'h7;
    localparam logic [3:0]  BIT_ACK         = 4'h8;
    localparam logic [3:0]  BIT_ZERO        = 4'h0;
    localparam logic [6:0]  ARRAY_FIRST     = 7'h00;
    localparam logic [6:0]  ARRAY_LAST      = 7'h7f;
    localparam int          PAGE_BYTES      = 16;
    localparam int          CLK_HZ          = 20_000_000;
    localparam int          TWC_MS          = 5;        // longest write cycle
    // longest time rounds down
    localparam int          TWC_CYCLES      = (CLK_HZ / 1000) * TWC_MS;

    typedef struct packed {
        logic scl;
        logic sda;
    } ets_line_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
    } ets_event_t;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_CTRL  = 5'h02,
        ST_WRITE = 5'h04,
        ST_READ  = 5'h08,
        ST_IGN   = 5'h10
    } ets_state_t;
endpackage : ets_pkg

/* File: verilog/ets_line_sync.sv */
// two-flop synchroniser and edge finder for the serial clock and data pins
`timescale 1ns/1ps
module ets_line_sync
    import ets_pkg::*;
(
    input  wire logic       I_CLOCK,
    input  wire logic       I_RST,
    input  wire ets_line_t  i_line,
    output ets_line_t       o_line,
    output ets_event_t      o_event
);
    ets_line_t meta;
    ets_line_t sync;
    ets_line_t prev;

    // first stage is read only by the second
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            meta <= '{scl: 1'h1, sda: 1'h1};
            sync <= '{scl: 1'h1, sda: 1'h1};
            prev <= '{scl: 1'h1, sda: 1'h1};
        end else begin
            meta <= i_line;
            sync <= meta;
            prev <= sync;
        end
    end

    // conditions come from comparing successive samples
    always_comb begin
        o_line        = sync;
        o_event.start = prev.scl && sync.scl && prev.sda && !sync.sda;
        o_event.stop  = prev.scl && sync.scl && !prev.sda && sync.sda;
        o_event.rise  = !prev.scl && sync.scl;
        o_event.fall  = prev.scl && !sync.scl;
    end
endmodule : ets_line_sync

/* File: verilog/ets_slave.sv */
// two-wire eeprom slave front end: conditions, bit shifting, control byte and acknowledge
`timescale 1ns/1ps
module ets_slave
    import ets_pkg::*;
#(
    parameter int  TWC_COUNT  = TWC_CYCLES,
    parameter bit  HAS_WP_PIN = 1'b1,
    parameter int  PAGE_DEPTH = PAGE_BYTES
)
(
    input  wire logic        I_CLOCK,
    input  wire logic        I_RST,
    input  wire logic        I_SCL,
    input  wire logic        I_SDA,
    input  wire logic        I_CHIP_SEL_PIN_LOW,
    input  wire logic        I_CHIP_SEL_PIN_MID,
    input  wire logic        I_CHIP_SEL_PIN_HIGH,
    input  wire logic        I_WP,
    input  wire logic [7:0]  I_RD_DATA,
    output logic             O_SDA_OUT,
    output logic             O_SDA_OE,
    output logic             O_SELECTED,
    output logic             O_READ_MODE,
    output logic             O_WRITE_MODE,
    output logic             O_BUSY,
    output logic             O_RD_NEXT,
    output logic             O_WR_STROBE,
    output logic [7:0]       O_WR_DATA,
    output logic [4:0]       O_WR_COUNT,
    output logic             O_WR_DROP
);
    localparam int TW = $clog2(TWC_COUNT + 1);

    ets_line_t   line;
    ets_event_t  ev;
    ets_state_t  state;
    ets_state_t  next_state;
    logic [3:0]  bit_cnt;
    logic [7:0]  shift;
    logic [7:0]  tx;
    logic        ack_phase;
    logic        master_nak;
    logic        wrote;
    logic [TW-1:0] twc;
    logic [2:0]  cs_pins;
    logic        pulse_seen;
    logic        rd_first;
    logic        wp_meta;
    logic        wp_sync;
    logic [2:0]  cs_sync;
    logic [7:0]  page_mem [PAGE_DEPTH];
    logic [3:0]  page_wr;
    logic        is_protected;

    ets_line_sync u_sync (
        .I_CLOCK (I_CLOCK),
        .I_RST   (I_RST),
        .i_line  ('{scl: I_SCL, sda: I_SDA}),
        .o_line  (line),
        .o_event (ev)
    );

    function automatic logic ctrl_match(input logic [7:0] b, input logic [2:0] pins);
        ctrl_match = (b[CODE_MSB:CODE_LSB] == CTRL_CODE) && (b[CS_MSB:CS_LSB] == pins);
    endfunction : ctrl_match

    // strap and protect pins are slow levels, still synchronised
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            cs_pins <= 3'h0;
            cs_sync <= 3'h0;
            wp_meta <= 1'h0;
            wp_sync <= 1'h0;
        end else begin
            cs_pins <= {I_CHIP_SEL_PIN_HIGH, I_CHIP_SEL_PIN_MID, I_CHIP_SEL_PIN_LOW};
            cs_sync <= cs_pins;
            wp_meta <= I_WP;
            wp_sync <= wp_meta;
        end
    end

    // whole array 00h-7Fh guarded by one pin, so no address compare is needed
    assign is_protected = HAS_WP_PIN && wp_sync;

    // the clock fall that closes a start is no pulse, so only a fall after a rise ends a bit
    always_ff @(posedge I_CLOCK) begin
        if (I_RST || ev.start || ev.stop) begin
            pulse_seen <= 1'h0;
        end else if (ev.rise) begin
            pulse_seen <= 1'h1;
        end else if (ev.fall) begin
            pulse_seen <= 1'h0;
        end
    end

    // bit counter: one bit per clock pulse, ninth pulse is acknowledge
    always_ff @(posedge I_CLOCK) begin
        if (I_RST || ev.start || ev.stop) begin
            bit_cnt <= BIT_ZERO;
        end else if (ev.fall && pulse_seen) begin
            bit_cnt <= (bit_cnt == BIT_ACK) ? BIT_ZERO : bit_cnt + 4'h1;
        end
    end

    // sample while clock high, on its rising edge
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            shift      <= 8'h00;
            master_nak <= 1'h0;
        end else if (ev.rise) begin
            if (bit_cnt <= BIT_LAST) begin
                shift <= {shift[6:0], line.sda};
            end else begin
                master_nak <= line.sda;
            end
        end
    end

    assign ack_phase = (bit_cnt == BIT_ACK);

    // control state machine
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE:  next_state = state;
            ST_CTRL: begin
                if (ev.fall && bit_cnt == BIT_LAST) begin
                    if (O_BUSY || !ctrl_match(shift, cs_sync)) begin
                        next_state = ST_IGN;
                    end else if (shift[RW_BIT] == RW_READ) begin
                        next_state = ST_READ;
                    end else begin
                        next_state = ST_WRITE;
                    end
                end
            end
            ST_READ: begin
                if (ev.fall && ack_phase && master_nak) begin
                    next_state = ST_IGN;
                end
            end
            ST_WRITE: next_state = state;
            ST_IGN:   next_state = state;
            default:  next_state = ST_IDLE;
        endcase
        if (ev.stop) begin
            next_state = ST_IDLE;
        end
        if (ev.start) begin
            next_state = ST_CTRL;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // page buffer: byte index wraps, so the newest sixteen survive
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            page_wr     <= 4'h0;
            O_WR_COUNT  <= 5'h00;
            O_WR_STROBE <= 1'h0;
            O_WR_DATA   <= 8'h00;
            wrote       <= 1'h0;
        end else begin
            O_WR_STROBE <= 1'h0;
            if (ev.start) begin
                page_wr    <= 4'h0;
                O_WR_COUNT <= 5'h00;
                wrote      <= 1'h0;
            end else if (state == ST_WRITE && ev.fall && bit_cnt == BIT_LAST) begin
                page_mem[page_wr] <= shift;
                page_wr     <= page_wr + 4'h1;
                wrote       <= 1'h1;
                O_WR_DATA   <= shift;
                O_WR_STROBE <= !is_protected;
                if (O_WR_COUNT < 5'(PAGE_DEPTH)) begin
                    O_WR_COUNT <= O_WR_COUNT + 5'h01;
                end
            end
        end
    end

    // self-timed write cycle; runs even when protected
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            O_BUSY <= 1'h0;
            twc    <= '0;
        end else if (ev.stop && state == ST_WRITE && wrote) begin
            O_BUSY <= 1'h1;
            twc    <= TW'(TWC_COUNT - 1);
        end else if (O_BUSY) begin
            if (twc == '0) begin
                O_BUSY <= 1'h0;
            end else begin
                twc <= twc - 1'b1;
            end
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            O_WR_DROP <= 1'h0;
        end else if (ev.start) begin
            O_WR_DROP <= 1'h0;
        end else if (ev.stop && state == ST_WRITE && wrote) begin
            O_WR_DROP <= is_protected;
        end
    end

    // read data shifter; reload at each byte start, pointer kept outside and advanced by O_RD_NEXT
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            tx        <= 8'h00;
            O_RD_NEXT <= 1'h0;
            rd_first  <= 1'h0;
        end else begin
            O_RD_NEXT <= 1'h0;
            if (next_state == ST_READ && state == ST_CTRL) begin
                tx       <= I_RD_DATA;
                rd_first <= 1'h1;
            end else if (state == ST_READ && ev.fall) begin
                if (ack_phase) begin
                    // first acknowledge is our own after the control byte: nothing read yet
                    tx        <= I_RD_DATA;
                    O_RD_NEXT <= !master_nak && !rd_first;
                    rd_first  <= 1'h0;
                end else if (bit_cnt != BIT_LAST) begin
                    tx <= {tx[6:0], 1'h0};
                end
            end
        end
    end

    // data pin driven only low; changed on clock fall, released at start or stop
    always_ff @(posedge I_CLOCK) begin
        if (I_RST || ev.start || ev.stop) begin
            O_SDA_OE <= 1'h0;
        end else if (ev.fall) begin
            if (state == ST_CTRL && bit_cnt == BIT_LAST) begin
                O_SDA_OE <= !O_BUSY && ctrl_match(shift, cs_sync);
            end else if (state == ST_WRITE && bit_cnt == BIT_LAST) begin
                O_SDA_OE <= 1'h1;
            end else if (state == ST_READ && ack_phase) begin
                O_SDA_OE <= !master_nak && !I_RD_DATA[7];
            end else if (state == ST_READ && bit_cnt < BIT_LAST) begin
                O_SDA_OE <= !tx[6];
            end else if (next_state == ST_READ && state == ST_CTRL) begin
                O_SDA_OE <= 1'h0;
            end else begin
                O_SDA_OE <= 1'h0;  // held low through ack high phase, released after
            end
        end else if (state == ST_CTRL && next_state == ST_READ) begin
            O_SDA_OE <= 1'h0;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            O_SDA_OUT    <= 1'h0;
            O_SELECTED   <= 1'h0;
            O_READ_MODE  <= 1'h0;
            O_WRITE_MODE <= 1'h0;
        end else begin
            O_SDA_OUT    <= 1'h0;
            O_SELECTED   <= (next_state == ST_READ) || (next_state == ST_WRITE);
            O_READ_MODE  <= (next_state == ST_READ);
            O_WRITE_MODE <= (next_state == ST_WRITE);
        end
    end
endmodule : ets_slave

/* File: sim/ets_master.sv */
// two-wire bus master model: makes the serial clock and pulls the data line
`timescale 1ns/1ps
module ets_master (
    output logic o_scl,
    output logic o_pull,
    input  wire  i_sda
);
    // clock rests high between frames and the bus starts idle
    initial begin
        o_scl  = 1'b1;
        o_pull = 1'b0;
    end
    task automatic start();
        o_pull = 1'b1;
        #200 o_scl = 1'b0;
    endtask : start
    task automatic stop();
        #100 o_pull = 1'b1;
        #100 o_scl = 1'b1;
        #200 o_pull = 1'b0;
        #200;
    endtask : stop
    task automatic put(input logic v);
        #100 o_pull = !v;
        #100 o_scl = 1'b1;
        #200 o_scl = 1'b0;
    endtask : put
    task automatic get(output logic v);
        #100 o_pull = 1'b0;
        #100 o_scl = 1'b1;
        #100 v = i_sda;
        #100 o_scl = 1'b0;
    endtask : get
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic n;
        for (int i = 7; i >= 0; i--) put(b[i]);
        get(n);
        ack = !n;
    endtask : wbyte
    task automatic rbyte(output logic [7:0] d);
        for (int i = 7; i >= 0; i--) get(d[i]);
    endtask : rbyte
endmodule : ets_master

/* File: sim/ets_slave_props.sv */
// concurrent checks on the ports of the two-wire eeprom slave front end
`timescale 1ns/1ps
module ets_slave_props
    import ets_pkg::*;
#(
    parameter int TWC_COUNT  = TWC_CYCLES,
    parameter bit HAS_WP_PIN = 1'b1
)
(
    input wire logic       I_CLOCK,
    input wire logic       I_RST,
    input wire logic       I_SCL,
    input wire logic       I_WP,
    input wire logic       O_SDA_OUT,
    input wire logic       O_SDA_OE,
    input wire logic       O_SELECTED,
    input wire logic       O_READ_MODE,
    input wire logic       O_WRITE_MODE,
    input wire logic       O_BUSY,
    input wire logic       O_RD_NEXT,
    input wire logic       O_WR_STROBE,
    input wire logic [4:0] O_WR_COUNT
);
    logic [31:0] busy_len;
    always_ff @(posedge I_CLOCK) begin
        busy_len <= (I_RST || !O_BUSY) ? 32'h0 : busy_len + 32'h1;
    end
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);
    AST_OPEN_DRAIN: assert property (O_SDA_OUT == 1'b0)
        else $error("data value not low");
    AST_ACK_HOLD: assert property ($rose(I_SCL) && O_SDA_OE |=> O_SDA_OE [*3])
        else $error("pull dropped in clock high");
    AST_BUSY_QUIET: assert property (O_BUSY |-> !O_SDA_OE)
        else $error("pull while busy");
    AST_ONE_MODE: assert property (!(O_READ_MODE && O_WRITE_MODE))
        else $error("read and write together");
    AST_SEL_MODE: assert property (O_SELECTED == (O_READ_MODE || O_WRITE_MODE))
        else $error("selected without mode");
    AST_WP_BLOCK: assert property (HAS_WP_PIN && I_WP && $past(I_WP, 8) |-> !O_WR_STROBE)
        else $error("store while protected");
    AST_BUSY_MAX: assert property (O_BUSY |-> busy_len <= TWC_COUNT)
        else $error("write cycle too long");
    AST_BUSY_MIN: assert property ($fell(O_BUSY) |-> $past(busy_len) >= TWC_COUNT - 2)
        else $error("write cycle too short");
    AST_COUNT_CAP: assert property (O_WR_COUNT <= 5'h10)
        else $error("byte count past sixteen");
    AST_STROBE_MODE: assert property (O_WR_STROBE |-> O_WRITE_MODE)
        else $error("store outside write");
    AST_READ_ADV: assert property (O_RD_NEXT |-> O_READ_MODE)
        else $error("advance outside read");
endmodule : ets_slave_props
bind ets_slave ets_slave_props #(.TWC_COUNT(TWC_COUNT), .HAS_WP_PIN(HAS_WP_PIN)) u_props (
    .I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_SCL(I_SCL), .I_WP(I_WP), .O_SDA_OUT(O_SDA_OUT), .O_SDA_OE(O_SDA_OE),
    .O_SELECTED(O_SELECTED), .O_READ_MODE(O_READ_MODE), .O_WRITE_MODE(O_WRITE_MODE), .O_BUSY(O_BUSY),
    .O_RD_NEXT(O_RD_NEXT), .O_WR_STROBE(O_WR_STROBE), .O_WR_COUNT(O_WR_COUNT));

/* File: sim/ets_slave_tb.sv */
// self-checking bench for the two-wire eeprom slave front end
`timescale 1ns/1ps
module ets_slave_tb;
    import ets_pkg::*;
    logic       clk, rst, wp, scl, pull, oe, so, sel, rdm, wrm, busy, rdn, stb, drop, a;
    logic [2:0] cs;
    logic       oe2, stb2, drop2;
    wire  [2:0] cs2 = {1'b0, !cs[1], cs[0]};  // reduced variant: highest select pin absent, held low
    logic [4:0] cnt;
    logic [7:0] rd, wd, d, b, lastb;
    int         miscompares, comparisons, nstb, nrd, n0, cyc, k, nstb2;
    wire        sda = !(pull || oe || oe2);  // pull-up unless someone pulls low
    ets_master m (.o_scl(scl), .o_pull(pull), .i_sda(sda));
    // short write cycle keeps the run brief
    ets_slave #(.TWC_COUNT(400)) dut (.I_CLOCK(clk), .I_RST(rst), .I_SCL(scl), .I_SDA(sda),
        .I_CHIP_SEL_PIN_LOW(cs[0]), .I_CHIP_SEL_PIN_MID(cs[1]), .I_CHIP_SEL_PIN_HIGH(cs[2]), .I_WP(wp),
        .I_RD_DATA(rd), .O_SDA_OUT(so), .O_SDA_OE(oe), .O_SELECTED(sel), .O_READ_MODE(rdm),
        .O_WRITE_MODE(wrm), .O_BUSY(busy), .O_RD_NEXT(rdn), .O_WR_STROBE(stb), .O_WR_DATA(wd),
        .O_WR_COUNT(cnt), .O_WR_DROP(drop));
    // second device on the same bus: variant with no protect pin
    ets_slave #(.TWC_COUNT(400), .HAS_WP_PIN(1'b0)) nowp (.I_CLOCK(clk), .I_RST(rst), .I_SCL(scl), .I_SDA(sda),
        .I_CHIP_SEL_PIN_LOW(cs2[0]), .I_CHIP_SEL_PIN_MID(cs2[1]), .I_CHIP_SEL_PIN_HIGH(cs2[2]), .I_WP(wp),
        .I_RD_DATA(rd), .O_SDA_OUT(), .O_SDA_OE(oe2), .O_SELECTED(), .O_READ_MODE(), .O_WRITE_MODE(),
        .O_BUSY(), .O_RD_NEXT(), .O_WR_STROBE(stb2), .O_WR_DATA(), .O_WR_COUNT(), .O_WR_DROP(drop2));
    initial begin
        clk = 1'b0;
        forever #25 clk = !clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (stb) begin
            nstb++;
            lastb = wd;
        end
        if (rdn) nrd++;
        if (stb2) nstb2++;
        if (cyc == 30000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic ctrl(input logic [3:0] c, input logic [2:0] s, input logic r);
        m.start();
        m.wbyte({c, s, r}, a);
    endtask : ctrl
    task automatic idle();
        for (k = 0; k < 600 && busy !== 1'b0; k++) @(negedge clk);
    endtask : idle
    task automatic conclude();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude
    initial begin
        rst = 1'b1;
        wp = 1'b0;
        rd = 8'h00;
        cs = 3'h0;
        void'($urandom(32'h0834));
        cs = 3'($urandom) | 3'h4;  // full variant straps its highest pin high
        repeat (20) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        // eighteen bytes overrun the sixteen-byte buffer
        ctrl(CTRL_CODE, cs, 1'b0);
        chk(a, 8'h01);
        chk(wrm, 8'h01);
        for (int i = 0; i < 18; i++) begin
            b = 8'($urandom);
            m.wbyte(b, a);
            chk(a, 8'h01);
        end
        chk(cnt, 8'h10);
        chk(8'(nstb), 8'h12);
        chk(lastb, b);
        m.stop();
        repeat (4) @(negedge clk);
        chk(busy, 8'h01);
        chk(drop, 8'h00);
        ctrl(CTRL_CODE, cs, 1'b0);
        chk(a, 8'h00);
        m.stop();
        idle();
        chk(busy, 8'h00);
        // one wrong chip-select bit at a time, then a wrong code
        for (int j = 0; j < 4; j++) begin
            ctrl((j == 3) ? ~CTRL_CODE : CTRL_CODE, (j == 3) ? cs : cs ^ 3'(1 << j), 1'b0);
            chk(a, 8'h00);
            m.wbyte(8'h00, a);
            chk(a, 8'h00);
            chk(sel, 8'h00);
            m.stop();
        end
        rd = 8'($urandom);
        ctrl(CTRL_CODE, cs, 1'b1);
        chk(a, 8'h01);
        chk(rdm, 8'h01);
        for (int i = 0; i < 2; i++) begin
            m.rbyte(d);
            chk(d, rd);
            rd = 8'($urandom);
            m.put(i == 1);
        end
        m.get(a);
        chk(a, 8'h01);
        m.stop();
        chk(8'(nrd), 8'h01);
        // protected write is still acknowledged but stores nothing
        wp = 1'b1;
        n0 = nstb;
        ctrl(CTRL_CODE, cs, 1'b0);
        chk(a, 8'h01);
        m.wbyte(8'($urandom), a);
        m.wbyte(8'($urandom), a);
        chk(a, 8'h01);
        chk(8'(nstb - n0), 8'h00);
        m.stop();
        repeat (4) @(negedge clk);
        chk(drop, 8'h01);
        chk(busy, 8'h01);
        idle();
        // the variant without protect pin stores even with the pin high
        n0 = nstb2;
        ctrl(CTRL_CODE, cs2, 1'b0);
        chk(a, 8'h01);
        m.wbyte(8'($urandom), a);
        chk(a, 8'h01);
        chk(8'(nstb2 - n0), 8'h01);
        m.stop();
        repeat (4) @(negedge clk);
        chk(drop2, 8'h00);
        conclude();
    end
endmodule : ets_slave_tb
